// >>> adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock rates and derived divider counts
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ     = 10_000_000; // Core clock rate
  localparam int INT_CLK_SLOW_HZ = 225_000;    // Conversion clock, shutdown pin driven high
  localparam int INT_CLK_FAST_HZ = 1_800_000;  // Conversion clock, shutdown pin floating
  // Longest period rounds down so the step rate never falls below the target
  localparam int DIV_SLOW_CYC    = CORE_CLK_HZ / INT_CLK_SLOW_HZ;
  localparam int DIV_FAST_CYC    = CORE_CLK_HZ / INT_CLK_FAST_HZ;
  localparam int DIV_W           = 6;          // Divider counter width
  localparam logic [DIV_W-1:0] DIV_SLOW_LOAD = DIV_W'(DIV_SLOW_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_FAST_LOAD = DIV_W'(DIV_FAST_CYC - 1);

  // ----------------------------------------------------------------
  // Result and control byte layout
  // ----------------------------------------------------------------
  localparam int RES_BITS = 10;                          // Result width
  localparam logic [3:0] RES_COUNT      = 4'ha;          // Bits shifted per result
  localparam logic [3:0] LAST_STEP      = 4'h9;          // Final approximation step
  localparam logic [3:0] START_OPEN_CNT = 4'h3;          // Bits left once result bit 3 is out
  localparam logic [3:0] CTRL_LAST_BIT  = 4'h7;          // Count at the eighth control bit
  localparam logic [3:0] TRACK_FROM_BIT = 4'h4;          // Tracking over the last four bits
  localparam int CB_SEL_HI = 6;                          // Channel select field, top
  localparam int CB_SEL_LO = 4;                          // Channel select field, bottom
  localparam int CB_UNI    = 3;                          // Unipolar select
  localparam int CB_SGL    = 2;                          // Single-ended select
  localparam int CB_PM_HI  = 1;                          // power_mode_bit_high
  localparam int CB_PM_LO  = 0;                          // power_mode_bit_low
  localparam logic [RES_BITS-1:0] SAR_INIT  = 10'h200;   // First trial code
  localparam logic [RES_BITS-1:0] RES_RESET = 10'h000;   // Result before first conversion
  localparam logic [7:0]          CTRL_FIRST = 8'h01;    // Start bit as received

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SY_W     = 6;
  localparam int SY_SCLK  = 0;
  localparam int SY_CS_N  = 1;
  localparam int SY_DIN   = 2;
  localparam int SY_LEVEL = 3;
  localparam int SY_FLOAT = 4;
  localparam int SY_COMP  = 5;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_FULL_PD = 2'b00,
    PM_FAST_PD = 2'b01,
    PM_INT_CLK = 2'b10,
    PM_EXT_CLK = 2'b11
  } power_mode_type;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_INT  = 2'b01,
    CV_EXT  = 2'b10
  } conv_state_type;

  typedef enum logic [1:0] {
    PW_ON   = 2'b00,
    PW_FAST = 2'b01,
    PW_FULL = 2'b10
  } pwr_state_type;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the core clock domain
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by the second

  // ----------------------------------------------------------------
  // Two flops per lane
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// >>> serial_adc_conversion_control.sv
`timescale 1ns/1ps
// Functional notes
// - Internal mode steps run from own oscillator
// - Strobe low during internal conversion, high after
// - Result held; MSB first on falls
// - Chip select high blocks input, floats output
// - Strobe keeps driving in internal mode
// - First sampled one is the start bit
// - Conversion starts on fall after bit eight
// - Start accepted after bit three, not mid internal conversion
// - Chip select toggle lets new byte abort
// - Back-to-back conversions every fifteen clocks
// - Reset: internal mode, strobe high
// - Zeros shifted out before first conversion
// - Floating pin selects external compensation
// - Low two bits pick power and clock
// - Serial interface alive in software power-down
// - Shutdown pin low overrides power bits, conversion and input
// - Oscillator rate set by shutdown pin state
// - Power-down after conversion; start powers up
// - Hardware shutdown halts conversion at once
// - External mode: strobe pulse, ten decisions
module serial_adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input  wire logic                              core_clk_i,
  input  wire logic                              srst_i,
  input  wire logic                              sclk_i,                 // Serial clock pin
  input  wire logic                              cs_n_i,                 // Chip select, low active
  input  wire logic                              din_i,                  // Serial data in
  input  wire logic                              shutdown_pin_level_i,   // Sensed pin level
  input  wire logic                              shutdown_pin_float_i,   // Pin left undriven
  input  wire logic                              comp_i,                 // Comparator decision
  output logic                                   dout_o,                 // Serial data out
  output logic                                   dout_oe_o,              // Serial out driven
  output logic                                   conversion_strobe_o,    // Strobe level
  output logic                                   conversion_strobe_oe_o, // Strobe driven
  output logic [adc_ctrl_pkg::RES_BITS-1:0]      dac_code_o,             // Trial code
  output logic                                   track_o,                // Track/hold in track
  output logic [2:0]                             channel_sel_o,          // Channel select
  output logic                                   unipolar_o,             // Unipolar input
  output logic                                   single_ended_o,         // Single-ended input
  output logic                                   converter_on_o,         // Analog core powered
  output logic                                   ref_on_o,               // Bandgap powered
  output logic                                   comp_internal_o,        // Internal compensation
  output logic                                   ext_clk_mode_o          // External clock mode
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [SY_W-1:0] sy;   // Synchronised pins
  logic sclk_rise;       // Serial clock rising edge seen
  logic sclk_fall;       // Serial clock falling edge seen
  logic cs_act;          // Chip select asserted
  logic hw_off;          // Shutdown pin driven low
  logic search_ok;       // A start bit may be taken

  pin_sync #(.WIDTH(SY_W)) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({comp_i, shutdown_pin_float_i, shutdown_pin_level_i, din_i, cs_n_i, sclk_i}),
    .sync_o     (sy)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                sclk_prev_q, sclk_prev_d;   // Serial clock one cycle back
  logic                cs_prev_q, cs_prev_d;       // Chip select one cycle back
  logic [7:0]          ctrl_q, ctrl_d;             // Control byte shifter
  logic [3:0]          rx_cnt_q, rx_cnt_d;         // Control bits taken, 0 while searching
  logic                ctrl_done_q, ctrl_done_d;   // Byte complete, awaiting fall
  conv_state_type      state_q, state_d;           // Conversion state
  logic                ext_q, ext_d;               // Clock mode, 1 for external
  logic                pd_pend_q, pd_pend_d;       // Power down after this conversion
  logic                pd_full_q, pd_full_d;       // Pending power-down is full
  pwr_state_type       pwr_q, pwr_d;               // Software power state
  logic [RES_BITS-1:0] trial_q, trial_d;           // Approximation register
  logic [RES_BITS-1:0] res_q, res_d;               // Stored result
  logic [3:0]          step_q, step_d;             // Approximation step
  logic [DIV_W-1:0]    div_q, div_d;               // Oscillator divider
  logic [3:0]          out_cnt_q, out_cnt_d;       // Result bits still to shift
  logic                dout_q, dout_d;             // Serial out level
  logic                dout_oe_q, dout_oe_d;       // Serial out enable
  logic                strobe_q, strobe_d;         // Strobe level
  logic                strobe_oe_q, strobe_oe_d;   // Strobe enable
  logic                toggled_q, toggled_d;       // Chip select toggled mid internal conversion
  logic                track_q, track_d;           // Tracking flag
  logic [2:0]          sel_q, sel_d;               // Latched channel select
  logic                uni_q, uni_d;               // Latched unipolar bit
  logic                sgl_q, sgl_d;               // Latched single-ended bit
  logic                conv_on_q, conv_on_d;       // Analog core on
  logic                ref_on_q, ref_on_d;         // Reference on
  logic                cint_q, cint_d;             // Internal compensation

  // One approximation step: keep or drop the bit under trial, try the next
  function automatic logic [RES_BITS-1:0] sar_step(input logic [RES_BITS-1:0] t,
                                                   input logic [3:0]          st,
                                                   input logic                keep);
    logic [RES_BITS-1:0] r;
    logic [3:0]          b;
    r    = t;
    b    = LAST_STEP - st;
    r[b] = keep;
    if (b != 4'h0) begin
      r[b - 4'h1] = 1'b1;
    end
    return r;
  endfunction

  assign sclk_rise = sy[SY_SCLK] & ~sclk_prev_q;
  assign sclk_fall = ~sy[SY_SCLK] & sclk_prev_q;
  assign cs_act    = ~sy[SY_CS_N];
  assign hw_off    = ~sy[SY_LEVEL] & ~sy[SY_FLOAT];
  // After bit three outside an internal conversion; also after a toggle
  assign search_ok = toggled_q || ((state_q != CV_INT) && (out_cnt_q <= START_OPEN_CNT));

  // ----------------------------------------------------------------
  // Next-state logic for the whole block
  // ----------------------------------------------------------------
  always_comb begin
    sclk_prev_d = sy[SY_SCLK];
    cs_prev_d   = cs_act;
    ctrl_d      = ctrl_q;
    rx_cnt_d    = rx_cnt_q;
    ctrl_done_d = ctrl_done_q;
    state_d     = state_q;
    ext_d       = ext_q;
    pd_pend_d   = pd_pend_q;
    pd_full_d   = pd_full_q;
    pwr_d       = pwr_q;
    trial_d     = trial_q;
    res_d       = res_q;
    step_d      = step_q;
    div_d       = div_q;
    out_cnt_d   = out_cnt_q;
    dout_d      = dout_q;
    strobe_d    = strobe_q;
    toggled_d   = toggled_q;
    track_d     = track_q;
    sel_d       = sel_q;
    uni_d       = uni_q;
    sgl_d       = sgl_q;

    // Input taken only with chip select asserted; in any power state
    if (sclk_rise && cs_act) begin
      if (rx_cnt_q != 4'h0) begin
        // Rest of the control byte
        ctrl_d = {ctrl_q[6:0], sy[SY_DIN]};
        if (rx_cnt_q == TRACK_FROM_BIT) begin
          track_d = 1'b1;
        end
        if (rx_cnt_q == CTRL_LAST_BIT) begin
          rx_cnt_d    = 4'h0;
          ctrl_done_d = 1'b1;
        end else begin
          rx_cnt_d = rx_cnt_q + 4'h1;
        end
      end else if (sy[SY_DIN] && search_ok && !ctrl_done_q) begin
        // First one is the start bit
        ctrl_d   = CTRL_FIRST;
        rx_cnt_d = 4'h1;
        pwr_d    = PW_ON;
      end
    end

    if (sclk_fall && cs_act) begin
      if (ctrl_done_q) begin
        // Start on the fall after bit eight; a new byte takes priority
        ctrl_done_d = 1'b0;
        track_d     = 1'b0;
        toggled_d   = 1'b0;
        sel_d       = ctrl_q[CB_SEL_HI:CB_SEL_LO];
        uni_d       = ctrl_q[CB_UNI];
        sgl_d       = ctrl_q[CB_SGL];
        trial_d     = SAR_INIT;
        step_d      = 4'h0;
        pd_pend_d   = 1'b0;
        pd_full_d   = 1'b0;
        case (ctrl_q[CB_PM_HI:CB_PM_LO])
          PM_INT_CLK: ext_d = 1'b0;
          PM_EXT_CLK: ext_d = 1'b1;
          PM_FULL_PD: begin
            pd_pend_d = 1'b1;
            pd_full_d = 1'b1;
          end
          default:    pd_pend_d = 1'b1;
        endcase
        if (ext_d) begin
          // Strobe high for one serial clock
          state_d   = CV_EXT;
          strobe_d  = 1'b1;
          out_cnt_d = RES_COUNT;
        end else begin
          state_d  = CV_INT;
          strobe_d = 1'b0;
          div_d    = sy[SY_FLOAT] ? DIV_FAST_LOAD : DIV_SLOW_LOAD;
        end
      end else if (state_q == CV_EXT) begin
        strobe_d  = 1'b0;
        dout_d    = sy[SY_COMP];
        trial_d   = sar_step(trial_q, step_q, sy[SY_COMP]);
        out_cnt_d = out_cnt_q - 4'h1;
        step_d    = step_q + 4'h1;
        if (step_q == LAST_STEP) begin
          res_d   = trial_d;
          state_d = CV_IDLE;
          if (pd_pend_q) begin
            pwr_d = pd_full_q ? PW_FULL : PW_FAST;
          end
        end
      end else if (out_cnt_q != 4'h0) begin
        // Stored result, MSB first; zeros until a first conversion
        dout_d    = res_q[out_cnt_q - 4'h1];
        out_cnt_d = out_cnt_q - 4'h1;
      end else begin
        dout_d = 1'b0;
      end
    end

    // Steps paced by the internal oscillator, not the serial clock
    if (state_q == CV_INT) begin
      if (div_q != '0) begin
        div_d = div_q - DIV_W'(1);
      end else begin
        // Rate follows the shutdown pin state
        div_d   = sy[SY_FLOAT] ? DIV_FAST_LOAD : DIV_SLOW_LOAD;
        trial_d = sar_step(trial_q, step_q, sy[SY_COMP]);
        step_d  = step_q + 4'h1;
        if (step_q == LAST_STEP) begin
          // Strobe high at completion; result held for shifting
          res_d     = trial_d;
          out_cnt_d = RES_COUNT;
          strobe_d  = 1'b1;
          state_d   = CV_IDLE;
          if (pd_pend_q) begin
            pwr_d = pd_full_q ? PW_FULL : PW_FAST;
          end
        end
      end
    end

    if (!cs_act && cs_prev_q) begin
      rx_cnt_d    = 4'h0;
      ctrl_done_d = 1'b0;
      track_d     = 1'b0;
      // Internal conversion keeps running; note the toggle
      if (state_q == CV_INT) begin
        toggled_d = 1'b1;
      end
      // External conversion cannot go on without the serial clock
      if (state_q == CV_EXT) begin
        state_d  = CV_IDLE;
        strobe_d = 1'b0;
      end
    end

    // Hardware shutdown halts at once, no completion
    if (hw_off) begin
      state_d     = CV_IDLE;
      rx_cnt_d    = 4'h0;
      ctrl_done_d = 1'b0;
      track_d     = 1'b0;
      toggled_d   = 1'b0;
      strobe_d    = ~ext_q;
    end

    dout_oe_d   = cs_act;
    // Strobe always driven in internal mode
    strobe_oe_d = cs_act || !ext_d;
    conv_on_d   = !hw_off && (pwr_d == PW_ON);
    ref_on_d    = !hw_off && (pwr_d != PW_FULL);
    cint_d      = !sy[SY_FLOAT];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b0;
      ctrl_q      <= 8'h00;
      rx_cnt_q    <= 4'h0;
      ctrl_done_q <= 1'b0;
      state_q     <= CV_IDLE;
      ext_q       <= 1'b0;
      pd_pend_q   <= 1'b0;
      pd_full_q   <= 1'b0;
      pwr_q       <= PW_ON;
      trial_q     <= RES_RESET;
      res_q       <= RES_RESET;
      step_q      <= 4'h0;
      div_q       <= '0;
      out_cnt_q   <= 4'h0;
      dout_q      <= 1'b0;
      dout_oe_q   <= 1'b0;
      strobe_q    <= 1'b1;
      strobe_oe_q <= 1'b1;
      toggled_q   <= 1'b0;
      track_q     <= 1'b0;
      sel_q       <= 3'h0;
      uni_q       <= 1'b0;
      sgl_q       <= 1'b0;
      conv_on_q   <= 1'b0;
      ref_on_q    <= 1'b0;
      cint_q      <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q   <= cs_prev_d;
      ctrl_q      <= ctrl_d;
      rx_cnt_q    <= rx_cnt_d;
      ctrl_done_q <= ctrl_done_d;
      state_q     <= state_d;
      ext_q       <= ext_d;
      pd_pend_q   <= pd_pend_d;
      pd_full_q   <= pd_full_d;
      pwr_q       <= pwr_d;
      trial_q     <= trial_d;
      res_q       <= res_d;
      step_q      <= step_d;
      div_q       <= div_d;
      out_cnt_q   <= out_cnt_d;
      dout_q      <= dout_d;
      dout_oe_q   <= dout_oe_d;
      strobe_q    <= strobe_d;
      strobe_oe_q <= strobe_oe_d;
      toggled_q   <= toggled_d;
      track_q     <= track_d;
      sel_q       <= sel_d;
      uni_q       <= uni_d;
      sgl_q       <= sgl_d;
      conv_on_q   <= conv_on_d;
      ref_on_q    <= ref_on_d;
      cint_q      <= cint_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign dout_o                 = dout_q;
  assign dout_oe_o              = dout_oe_q;
  assign conversion_strobe_o    = strobe_q;
  assign conversion_strobe_oe_o = strobe_oe_q;
  assign dac_code_o             = trial_q;
  assign track_o                = track_q;
  assign channel_sel_o          = sel_q;
  assign unipolar_o             = uni_q;
  assign single_ended_o         = sgl_q;
  assign converter_on_o         = conv_on_q;
  assign ref_on_o               = ref_on_q;
  assign comp_internal_o        = cint_q;
  assign ext_clk_mode_o         = ext_q;

endmodule

// >>> adc_ctrl_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Port checker for the conversion control block
// ------------------------------------------------
module adc_ctrl_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic shutdown_pin_level_i,
  input wire logic shutdown_pin_float_i,
  input wire logic dout_oe_o,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe_o,
  input wire logic track_o,
  input wire logic converter_on_o,
  input wire logic comp_internal_o,
  input wire logic ext_clk_mode_o
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // Reset itself is checked here
  a_reset_state: assert property (disable iff (1'b0)
    srst_i |=> conversion_strobe_o && conversion_strobe_oe_o && !dout_oe_o)
    else $error("strobe or serial out wrong after reset");
  // Sync delay is three cycles
  a_cs_float: assert property (
    cs_n_i [*5] |-> !dout_oe_o)
    else $error("serial out driven while deselected");
  a_strobe_driven: assert property (
    !ext_clk_mode_o [*3] |-> conversion_strobe_oe_o)
    else $error("strobe floats in internal mode");
  // 7.5 us is 75 core cycles
  a_strobe_low_max: assert property (
    $fell(conversion_strobe_o) && !ext_clk_mode_o && !comp_internal_o
    |-> ##[1:75] conversion_strobe_o)
    else $error("internal conversion too long");
  a_hw_shutdown: assert property (
    (!shutdown_pin_level_i && !shutdown_pin_float_i) [*5] |-> !converter_on_o && !track_o)
    else $error("converter on with pin low");
  a_comp_external: assert property (
    shutdown_pin_float_i [*5] |-> !comp_internal_o)
    else $error("internal compensation with pin floating");
  a_comp_internal: assert property (
    (shutdown_pin_level_i && !shutdown_pin_float_i) [*5] |-> comp_internal_o)
    else $error("external compensation with pin high");
  a_no_cs_start: assert property (
    $fell(cs_n_i) && conversion_strobe_o && !ext_clk_mode_o |=> conversion_strobe_o [*8])
    else $error("select fall started a conversion");
  a_ext_pulse: assert property (
    $rose(conversion_strobe_o) && conversion_strobe_oe_o && ext_clk_mode_o
    |-> conversion_strobe_o [*4])
    else $error("external strobe pulse too short");

  c_int_done: cover property ($rose(conversion_strobe_o) && !ext_clk_mode_o);
  c_ext_pulse: cover property ($rose(conversion_strobe_o) && ext_clk_mode_o);
  c_shutdown: cover property ($fell(converter_on_o));
endmodule

bind serial_adc_conversion_control adc_ctrl_checker adc_ctrl_checker_inst (.*);

// >>> master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial master on the far side of the link
// ----------------------------------------
module master_model (
  input  wire logic core_clk_i,  // Bench clock
  input  wire logic dout_line_i, // Resolved serial out
  input  wire logic strb_line_i, // Resolved strobe
  output logic      sclk_o,      // Serial clock, idle low
  output logic      cs_n_o,      // Chip select
  output logic      din_o        // Serial data
);
  logic [15:0] rx_q; // Serial out samples
  logic [15:0] st_q; // Strobe samples
  // Idle link: clock parked low, device deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
    rx_q   = 16'h0000;
    st_q   = 16'h0000;
  end
  // Select change, then a half period of settling
  task automatic set_cs(input logic v);
    @(negedge core_clk_i);
    cs_n_o = v;
    repeat (4) @(negedge core_clk_i);
  endtask
  // rate within limits: 800 ns period
  task automatic bit_x(input logic d);
    @(negedge core_clk_i);
    din_o = d;
    repeat (3) @(negedge core_clk_i);
    sclk_o = 1'b1;
    repeat (3) @(negedge core_clk_i);
    // Sample late in the high half
    rx_q = {rx_q[14:0], dout_line_i};
    st_q = {st_q[14:0], strb_line_i};
    @(negedge core_clk_i);
    sclk_o = 1'b0;
  endtask
  // Whole byte, most significant bit first
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i]);
    end
  endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for conversion control
// ----------------------------------------
module tb;
  import adc_ctrl_pkg::*;
  logic                core_clk, srst, sclk, cs_n, din;   // Clock, reset, link
  logic                pin_level, pin_float, comp;         // Pin and comparator
  logic                dout, dout_oe, strobe, strobe_oe;  // Link outputs
  logic [RES_BITS-1:0] dac_code, vin;                     // Trial code, input code
  logic [2:0]          chan;                              // Latched channel
  logic                track, uni, sgl, conv_on, ref_on, comp_int, ext_mode;
  logic                dout_line, strb_line;              // Resolved lines
  int                  bad_count, num_checks, n;
  // Comparator: input at or above trial code
  assign comp      = (vin >= dac_code);
  // Undriven outputs float on the board
  assign dout_line = dout_oe ? dout : 1'bz;
  assign strb_line = strobe_oe ? strobe : 1'bz;
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  serial_adc_conversion_control serial_adc_conversion_control_inst (
    .core_clk_i(core_clk), .srst_i(srst), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .shutdown_pin_level_i(pin_level), .shutdown_pin_float_i(pin_float), .comp_i(comp),
    .dout_o(dout), .dout_oe_o(dout_oe), .conversion_strobe_o(strobe),
    .conversion_strobe_oe_o(strobe_oe), .dac_code_o(dac_code), .track_o(track),
    .channel_sel_o(chan), .unipolar_o(uni), .single_ended_o(sgl), .converter_on_o(conv_on),
    .ref_on_o(ref_on), .comp_internal_o(comp_int), .ext_clk_mode_o(ext_mode));
  master_model master_model_inst (
    .core_clk_i(core_clk), .dout_line_i(dout_line), .strb_line_i(strb_line),
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  // Bounded wait for a strobe level; n returns the cycles spent
  task automatic wait_strb(input logic v);
    n = 0;
    while (strobe !== v && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    check(16'(n < 1000), 16'h0001, "strobe wait");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under 20000 cycles
  initial begin
    repeat (50000) @(posedge core_clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    srst      = 1'b1;
    pin_level = 1'b0;
    pin_float = 1'b1;
    vin       = 10'h2a5;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    check({strobe, strobe_oe, dout_oe, ext_mode}, 16'h000c, "reset state");
    repeat (100) @(negedge core_clk);
    // zeros first with select held low
    master_model_inst.set_cs(1'b0);
    master_model_inst.send(8'h00);
    master_model_inst.send(8'h00);
    check(master_model_inst.rx_q, 16'h0000, "zeros before conversion");
    $display("test power-on done");
    // Internal clock conversion, deselected while it runs
    master_model_inst.send(8'h9e);
    wait_strb(1'b0);
    check(16'(n < 12), 16'h0001, "strobe fall delay");
    master_model_inst.set_cs(1'b1);
    check({dout_oe, strobe_oe, strobe}, 16'h0002, "deselected lines");
    wait_strb(1'b1);
    check({chan, uni, sgl, ext_mode, comp_int}, 16'h001c, "fields");
    master_model_inst.set_cs(1'b0);
    master_model_inst.send(8'h00);
    master_model_inst.send(8'h00);
    check(master_model_inst.rx_q[14:5], vin, "internal result");
    $display("test internal done");
    // Both power-down codes, boundary inputs
    for (int p = 0; p < 2; p++) begin
      vin = p[0] ? 10'h3ff : 10'h000;
      master_model_inst.send({7'b1001110, p[0]});
      check(conv_on, 1'b1, "powered by start bit");
      wait_strb(1'b0);
      wait_strb(1'b1);
      master_model_inst.send(8'h00);
      master_model_inst.send(8'h00);
      check(master_model_inst.rx_q[14:5], vin, "result in power-down");
      check({conv_on, ref_on}, {14'h0000, 1'b0, p[0]}, "power-down state");
      repeat (p[0] ? 50 : 3000) @(negedge core_clk);
    end
    $display("test power-down done");
    // Hardware shutdown mid slow conversion
    pin_level = 1'b1;
    pin_float = 1'b0;
    repeat (8) @(negedge core_clk);
    master_model_inst.send(8'h9e);
    wait_strb(1'b0);
    repeat (20) @(negedge core_clk);
    pin_level = 1'b0;
    repeat (6) @(negedge core_clk);
    check({conv_on, track, strobe, strobe_oe}, 16'h0003, "hardware shutdown");
    pin_level = 1'b1;
    repeat (6) @(negedge core_clk);
    check(comp_int, 1'b1, "internal compensation");
    pin_level = 1'b0;
    pin_float = 1'b1;
    repeat (6) @(negedge core_clk);
    $display("test shutdown done");
    // Partial byte dropped by a select toggle
    master_model_inst.bit_x(1'b1);
    master_model_inst.bit_x(1'b0);
    master_model_inst.bit_x(1'b1);
    master_model_inst.bit_x(1'b1);
    master_model_inst.set_cs(1'b1);
    master_model_inst.set_cs(1'b0);
    vin = 10'h15a;
    master_model_inst.send(8'h83);
    repeat (4) @(negedge core_clk);
    check({chan, ext_mode}, 16'h0001, "fields after toggle");
    for (int k = 0; k < 7; k++) begin
      master_model_inst.bit_x(1'b0);
    end
    // Start bit after result bit 3: 15 clocks
    master_model_inst.send(8'h93);
    repeat (4) @(negedge core_clk);
    check(master_model_inst.rx_q[13:4], 10'h15a, "first result");
    check({chan, ext_mode}, 16'h0003, "second byte taken");
    vin = 10'h0c3;
    master_model_inst.send(8'h00);
    master_model_inst.send(8'h00);
    check(master_model_inst.rx_q[14:5], vin, "external result");
    check(master_model_inst.st_q[15:14], 2'b10, "strobe pulse");
    master_model_inst.set_cs(1'b1);
    check(strobe_oe, 1'b0, "strobe floats");
    $display("test external done");
    final_report();
  end
endmodule
